// *** hw/bst_top.sv ***
// Boundary-scan test access logic: controller, instruction and data registers
// Operation
// - Sixteen-state controller, instruction register, data registers
// - No test reset pin; TMS sequence resets
// - Enabled scan makes three inputs, one output
// - Three boundary bits per I/O block
// - Group shift order: in, out, tristate
// - No cells for reprogram, config clock, done
// - EXTEST capture latches all boundary cells together
// - Bit 0 tristate, bit 1 value, last update
// - Input mode pins one cell, output pin three
// - Bypass is one flip-flop delay stage
// - Two user instructions decoded to select outputs
// - User instruction routes fabric scan out to TDO
// - Data register clock offered to fabric
// - Idle clock is NAND of TCK, idle
// - Configure and readback instructions also exist
// - Without scan macro, pins test-only during configuration
// - With scan macro, scan stays active afterwards
// - Test inputs still reach fabric as inputs
module bst_top
   import bst_pkg::*;
(
   // System
   input  wire logic                        i_mclk,
   input  wire logic                        i_sys_rst,
   // Test pins
   input  wire logic                        i_tck,
   input  wire logic                        i_tms,
   input  wire logic                        i_tdi,
   output logic                             o_tdo,
   output logic                             o_tdo_oe,
   // Configuration status
   input  wire logic                        i_config_done,
   input  wire logic                        i_scan_macro_used,
   // User function of the TDO pad when scan is inactive
   input  wire logic                        i_user_tdo_out,
   input  wire logic                        i_user_tdo_oe,
   // Test inputs as ordinary fabric inputs
   output logic                             o_fab_tck,
   output logic                             o_fab_tms,
   output logic                             o_fab_tdi,
   // I/O blocks
   input  wire logic [bst_pkg::NUM_IOB-1:0] i_pad_in,
   input  wire logic [bst_pkg::NUM_IOB-1:0] i_core_out,
   input  wire logic [bst_pkg::NUM_IOB-1:0] i_core_oe,
   output logic      [bst_pkg::NUM_IOB-1:0] o_pad_out,
   output logic      [bst_pkg::NUM_IOB-1:0] o_pad_oe,
   // Mode pins
   input  wire logic                        i_mode_pin_low,
   input  wire logic                        i_mode_pin_high,
   input  wire logic                        i_mode_pin_mid,
   input  wire logic                        i_mode_mid_core_out,
   input  wire logic                        i_mode_mid_core_oe,
   output logic                             o_mode_pin_mid_out,
   output logic                             o_mode_pin_mid_oe,
   // User scan macro
   output logic                             o_user_instr_one_select,
   output logic                             o_user_instr_two_select,
   input  wire logic                        i_user_chain_one_out,
   input  wire logic                        i_user_chain_two_out,
   output logic                             o_user_dr_shift_clock,
   output logic                             o_user_idle_clock,
   output logic                             o_internal_update_drive_bit,
   // Configuration and readback engines
   output logic                             o_configure_select,
   output logic                             o_readback_select,
   input  wire logic                        i_config_dout,
   input  wire logic                        i_readback_data
);

   typedef struct packed {
      logic [2:0]         tck_s;
      logic [2:0]         tms_s;
      logic [2:0]         tdi_s;
      logic               tck_f;
      bst_tap_t           tap;
      logic [IR_LEN-1:0]  ir_sh;
      logic [IR_LEN-1:0]  ir;
      logic [BSR_LEN-1:0] bsr_sh;
      logic [BSR_LEN-1:0] bsr_up;
      logic               byp;
      logic               tdo;
      logic               tdo_oe;
      logic               drck;
      logic               idle;
      logic               sel1;
      logic               sel2;
      logic               cfg_sel;
      logic               rb_sel;
      logic               fab_tck;
      logic               fab_tms;
      logic               fab_tdi;
      logic [NUM_IOB-1:0] pad_out;
      logic [NUM_IOB-1:0] pad_oe;
      logic               mid_out;
      logic               mid_oe;
   } bst_state_t;

   bst_state_t q;
   bst_state_t d;

   logic               rise;
   logic               fall;
   logic               active;
   logic               tms_v;
   logic               tdi_v;
   logic               bsr_sel;
   logic [BSR_LEN-1:0] cap;

   // A change counts once the second and third stages agree
   assign rise   = (q.tck_s[1] == q.tck_s[2]) && q.tck_s[2] && !q.tck_f;
   assign fall   = (q.tck_s[1] == q.tck_s[2]) && !q.tck_s[2] && q.tck_f;
   assign tms_v  = q.tms_s[2];
   assign tdi_v  = q.tdi_s[2];
   assign active = !i_config_done || i_scan_macro_used;
   assign bsr_sel = (q.ir == IR_EXTEST) || (q.ir == IR_SAMPLE);

   function automatic bst_tap_t tap_next(input bst_tap_t s, input logic m);
      case (s)
         TAP_TLR:    tap_next = m ? TAP_TLR    : TAP_RTI;
         TAP_RTI:    tap_next = m ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = m ? TAP_UP_DR  : TAP_PA_DR;
         TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: tap_next = m ? TAP_UP_DR  : TAP_SH_DR;
         TAP_UP_DR:  tap_next = m ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_IR: tap_next = m ? TAP_TLR    : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = m ? TAP_UP_IR  : TAP_PA_IR;
         TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: tap_next = m ? TAP_UP_IR  : TAP_SH_IR;
         TAP_UP_IR:  tap_next = m ? TAP_SEL_DR : TAP_RTI;
         default:    tap_next = TAP_TLR;
      endcase
   endfunction

   // Parallel capture image; the TDO pin and the mode pins get cells besides the I/O blocks
   always_comb begin
      cap = q.bsr_sh;
      cap[POS_TDO_T] = q.tdo_oe;
      cap[POS_TDO_O] = q.tdo;
      for (int i = 0; i < NUM_IOB; i++) begin
         cap[POS_IOB + 3 * i + OFS_IN]  = i_pad_in[i];
         cap[POS_IOB + 3 * i + OFS_OUT] = q.pad_out[i];
         cap[POS_IOB + 3 * i + OFS_TRI] = q.pad_oe[i];
      end
      cap[POS_MODE_LO] = i_mode_pin_low;
      cap[POS_MODE_HI] = i_mode_pin_high;
      cap[POS_MODE_MID + OFS_IN]  = i_mode_pin_mid;
      cap[POS_MODE_MID + OFS_OUT] = q.mid_out;
      cap[POS_MODE_MID + OFS_TRI] = q.mid_oe;
      cap[POS_UPD] = q.bsr_up[POS_UPD];
   end

   always_comb begin
      d = q;
      // Three-stage synchronisers on the test pins
      d.tck_s = {q.tck_s[1:0], i_tck};
      d.tms_s = {q.tms_s[1:0], i_tms};
      d.tdi_s = {q.tdi_s[1:0], i_tdi};
      if (q.tck_s[1] == q.tck_s[2]) begin
         d.tck_f = q.tck_s[2];
      end
      // Test inputs keep reaching the fabric
      d.fab_tck = q.tck_s[2];
      d.fab_tms = tms_v;
      d.fab_tdi = tdi_v;

      // Rising TCK: controller advance, capture and shift
      if (rise) begin
         d.tap = tap_next(q.tap, tms_v);
         case (q.tap)
            TAP_CAP_IR: begin
               d.ir_sh = IR_CAPTURE;
            end
            TAP_SH_IR: begin
               d.ir_sh = {tdi_v, q.ir_sh[IR_LEN-1:1]};
            end
            TAP_CAP_DR: begin
               if (bsr_sel) begin
                  d.bsr_sh = cap;
               end
               if (q.ir == IR_BYPASS || q.ir == IR_RESERVED) begin
                  d.byp = 1'b0;
               end
            end
            TAP_SH_DR: begin
               if (bsr_sel) begin
                  d.bsr_sh = {tdi_v, q.bsr_sh[BSR_LEN-1:1]};
               end
               d.byp = tdi_v;
            end
            default: begin
            end
         endcase
      end

      // Falling TCK: TDO launch and register updates
      if (fall) begin
         d.tdo_oe = (q.tap == TAP_SH_DR) || (q.tap == TAP_SH_IR);
         if (q.tap == TAP_SH_IR) begin
            d.tdo = q.ir_sh[0];
         end else begin
            case (q.ir)
               IR_EXTEST, IR_SAMPLE: d.tdo = q.bsr_sh[POS_TDO_T];
               IR_USER1:             d.tdo = i_user_chain_one_out;
               IR_USER2:             d.tdo = i_user_chain_two_out;
               IR_READBACK:          d.tdo = i_readback_data;
               IR_CONFIGURE:         d.tdo = i_config_dout;
               default:              d.tdo = q.byp;
            endcase
         end
         if (q.tap == TAP_UP_IR) begin
            d.ir = q.ir_sh;
         end
         if (q.tap == TAP_UP_DR && bsr_sel) begin
            d.bsr_up = q.bsr_sh;
         end
      end

      // Instruction falls back to bypass in reset state
      if (q.tap == TAP_TLR) begin
         d.ir = IR_BYPASS;
      end

      // Pins revert to user function once scan is dropped
      if (!active) begin
         d.tap    = TAP_TLR;
         d.ir     = IR_BYPASS;
         d.tdo    = i_user_tdo_out;
         d.tdo_oe = i_user_tdo_oe;
      end

      // Instruction decodes
      d.sel1    = (q.ir == IR_USER1);
      d.sel2    = (q.ir == IR_USER2);
      d.cfg_sel = (q.ir == IR_CONFIGURE);
      d.rb_sel  = (q.ir == IR_READBACK);

      // Data register clock to fabric, parked high outside user DR work
      if ((q.sel1 || q.sel2) && (q.tap == TAP_CAP_DR || q.tap == TAP_SH_DR)) begin
         d.drck = q.tck_f;
      end else begin
         d.drck = DRCK_RST;
      end
      d.idle = !(q.tck_f && (q.tap == TAP_RTI));

      // Pad drive: boundary cells under EXTEST, off under CONFIGURE
      if (q.ir == IR_EXTEST) begin
         for (int i = 0; i < NUM_IOB; i++) begin
            d.pad_out[i] = q.bsr_up[POS_IOB + 3 * i + OFS_OUT];
            d.pad_oe[i]  = q.bsr_up[POS_IOB + 3 * i + OFS_TRI];
         end
         d.mid_out = q.bsr_up[POS_MODE_MID + OFS_OUT];
         d.mid_oe  = q.bsr_up[POS_MODE_MID + OFS_TRI];
      end else if (q.ir == IR_CONFIGURE) begin
         d.pad_out = i_core_out;
         d.pad_oe  = '0;
         d.mid_out = i_mode_mid_core_out;
         d.mid_oe  = 1'b0;
      end else begin
         d.pad_out = i_core_out;
         d.pad_oe  = i_core_oe;
         d.mid_out = i_mode_mid_core_out;
         d.mid_oe  = i_mode_mid_core_oe;
      end
   end

   // Synchronous reset only; the test logic itself has no reset pin
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         q         <= '0;
         q.tck_s   <= SYNC_RST;
         q.tms_s   <= SYNC_RST;
         q.tdi_s   <= SYNC_RST;
         q.tap     <= TAP_TLR;
         q.ir      <= IR_BYPASS;
         q.ir_sh   <= IR_CAPTURE;
         q.drck    <= DRCK_RST;
         q.idle    <= IDLE_RST;
      end else begin
         q <= d;
      end
   end

   assign o_tdo                       = q.tdo;
   assign o_tdo_oe                    = q.tdo_oe;
   assign o_fab_tck                   = q.fab_tck;
   assign o_fab_tms                   = q.fab_tms;
   assign o_fab_tdi                   = q.fab_tdi;
   assign o_pad_out                   = q.pad_out;
   assign o_pad_oe                    = q.pad_oe;
   assign o_mode_pin_mid_out          = q.mid_out;
   assign o_mode_pin_mid_oe           = q.mid_oe;
   assign o_user_instr_one_select     = q.sel1;
   assign o_user_instr_two_select     = q.sel2;
   assign o_user_dr_shift_clock       = q.drck;
   assign o_user_idle_clock           = q.idle;
   assign o_internal_update_drive_bit = q.bsr_up[POS_UPD];
   assign o_configure_select          = q.cfg_sel;
   assign o_readback_select           = q.rb_sel;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   chk_tlr_bypass: assert property (
      q.tap == TAP_TLR |=> q.ir == IR_BYPASS)
      else $error("instruction not bypass after reset state");
   chk_inactive_tap_reset: assert property (
      !active |=> q.tap == TAP_TLR && o_tdo_oe == $past(i_user_tdo_oe))
      else $error("scan not released when inactive");
   chk_idle_clock_nand: assert property (
      (q.tap == TAP_RTI && q.tck_f) |=> !o_user_idle_clock)
      else $error("idle clock not low in idle with TCK high");
   chk_user_select_one: assert property (
      q.ir == IR_USER1 |=> o_user_instr_one_select && !o_user_instr_two_select)
      else $error("user select one wrong");
   chk_extest_capture: assert property (
      (rise && q.tap == TAP_CAP_DR && q.ir == IR_EXTEST && active)
      |=> q.bsr_sh[POS_IOB + OFS_IN] == $past(i_pad_in[0])
          && q.bsr_sh[POS_TDO_O] == $past(q.tdo))
      else $error("boundary capture missed");
   chk_bypass_stage: assert property (
      (rise && q.tap == TAP_SH_DR && q.ir == IR_BYPASS && active)
      |=> q.byp == $past(tdi_v))
      else $error("bypass stage wrong");
   chk_user_two_tdo: assert property (
      (fall && q.tap == TAP_SH_DR && q.ir == IR_USER2 && active)
      |=> o_tdo == $past(i_user_chain_two_out) && o_tdo_oe)
      else $error("user chain two not on TDO");
   chk_bsr_tdo_pos0: assert property (
      (fall && q.tap == TAP_SH_DR && q.ir == IR_EXTEST && active)
      |=> o_tdo == $past(q.bsr_sh[POS_TDO_T]))
      else $error("boundary bit 0 not on TDO");
   chk_extest_drive: assert property (
      (q.ir == IR_EXTEST && active) |=> o_pad_oe[0] == $past(q.bsr_up[POS_IOB + OFS_TRI])
          && o_pad_out[0] == $past(q.bsr_up[POS_IOB + OFS_OUT]))
      else $error("extest pad drive wrong");
   chk_fab_inputs: assert property (
      ##1 o_fab_tms == $past(tms_v))
      else $error("fabric TMS copy wrong");

   cov_shift_dr: cover property (rise && q.tap == TAP_SH_DR && q.ir == IR_EXTEST);
   cov_update_ir: cover property (fall && q.tap == TAP_UP_IR);
   cov_user_one: cover property (o_user_instr_one_select && !o_user_dr_shift_clock);

endmodule

// *** include/bst_pkg.sv ***
// Constants, codes and types of the boundary-scan test logic
package bst_pkg;

   // I/O blocks covered by the boundary register (fixed)
   localparam int NUM_IOB = 8;

   // Boundary register layout
   localparam int POS_TDO_T    = 0;
   localparam int POS_TDO_O    = 1;
   localparam int POS_IOB      = 2;
   localparam int POS_MODE_LO  = POS_IOB + 3 * NUM_IOB;
   localparam int POS_MODE_HI  = POS_MODE_LO + 1;
   localparam int POS_MODE_MID = POS_MODE_HI + 1;
   localparam int POS_UPD      = POS_MODE_MID + 3;
   localparam int BSR_LEN      = POS_UPD + 1;

   // Offsets inside one I/O block group, in shift order
   localparam int OFS_IN  = 0;
   localparam int OFS_OUT = 1;
   localparam int OFS_TRI = 2;

   // Instruction codes
   localparam int         IR_LEN       = 3;
   localparam logic [2:0] IR_EXTEST    = 3'h0;
   localparam logic [2:0] IR_SAMPLE    = 3'h1;
   localparam logic [2:0] IR_USER1     = 3'h2;
   localparam logic [2:0] IR_USER2     = 3'h3;
   localparam logic [2:0] IR_READBACK  = 3'h4;
   localparam logic [2:0] IR_CONFIGURE = 3'h5;
   localparam logic [2:0] IR_RESERVED  = 3'h6;
   localparam logic [2:0] IR_BYPASS    = 3'h7;
   localparam logic [2:0] IR_CAPTURE   = 3'h1;

   // Values after reset
   localparam logic [2:0] SYNC_RST   = 3'h0;
   localparam logic       DRCK_RST   = 1'b1;
   localparam logic       IDLE_RST   = 1'b1;

   // Controller states, Gray coded along the usual path
   typedef enum logic [3:0] {
      TAP_TLR    = 4'h0,
      TAP_RTI    = 4'h1,
      TAP_SEL_DR = 4'h3,
      TAP_CAP_DR = 4'h2,
      TAP_SH_DR  = 4'h6,
      TAP_EX1_DR = 4'h7,
      TAP_PA_DR  = 4'h5,
      TAP_EX2_DR = 4'h4,
      TAP_UP_DR  = 4'hC,
      TAP_SEL_IR = 4'hD,
      TAP_CAP_IR = 4'hF,
      TAP_SH_IR  = 4'hE,
      TAP_EX1_IR = 4'hA,
      TAP_PA_IR  = 4'hB,
      TAP_EX2_IR = 4'h9,
      TAP_UP_IR  = 4'h8
   } bst_tap_t;

endpackage

// *** tb/bst_jtag_model.sv ***
// Board-side test controller that drives the four-wire scan link
module bst_jtag_model (
   // System
   input  wire logic i_mclk,
   // Link
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end

   // One bit of 125 ns; TDO taken just before the rise, as a real controller does
   task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
      @(posedge i_mclk);
      o_tck <= 1'b0;
      o_tms <= tms;
      o_tdi <= tdi;
      repeat (13) @(posedge i_mclk);
      // Released pad floats to its weak pull-up, so a missing drive shows up
      tdo = i_tdo_oe ? i_tdo : 1'b1;
      oe = i_tdo_oe;
      o_tck <= 1'b1;
      repeat (11) @(posedge i_mclk);
   endtask

   // Clock stands between frames; TMS parked high, TDI no longer holds its value
   task automatic park();
      @(posedge i_mclk);
      o_tms <= 1'b1;
      o_tdi <= ~o_tdi;
   endtask

   // No reset pin: five rises with TMS high, then into Run-Test/Idle
   task automatic reset_tap();
      logic t, e;
      repeat (5) step(1'b1, 1'b0, t, e);
      step(1'b0, 1'b0, t, e);
      park();
   endtask

   // Full scan from Run-Test/Idle back to Run-Test/Idle, LSB first
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout, output logic oe_all);
      logic t, e;
      dout = '0;
      oe_all = 1'b1;
      step(1'b1, 1'b0, t, e);
      if (ir) step(1'b1, 1'b0, t, e);
      step(1'b0, 1'b0, t, e);
      step(1'b0, 1'b0, t, e);
      for (int k = 0; k < n; k++) begin
         step(k == n - 1, din[k], t, e);
         dout[k] = t;
         oe_all &= e;
      end
      step(1'b1, 1'b0, t, e);
      step(1'b0, 1'b0, t, e);
      park();
   endtask
endmodule

// *** tb/boundary_scan_test_logic_bench.sv ***
// Self-checking bench of the boundary-scan test logic
module boundary_scan_test_logic_bench import bst_pkg::*; ();
   timeunit 1ns;
   timeprecision 100ps;

   logic i_mclk, i_sys_rst, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe;
   logic i_config_done, i_scan_macro_used, i_user_tdo_out, i_user_tdo_oe;
   logic o_fab_tck, o_fab_tms, o_fab_tdi;
   logic [NUM_IOB-1:0] i_pad_in, i_core_out, i_core_oe, o_pad_out, o_pad_oe;
   logic i_mode_pin_low, i_mode_pin_high, i_mode_pin_mid, i_mode_mid_core_out;
   logic i_mode_mid_core_oe, o_mode_pin_mid_out, o_mode_pin_mid_oe;
   logic o_user_instr_one_select, o_user_instr_two_select;
   logic i_user_chain_one_out, i_user_chain_two_out, o_user_dr_shift_clock;
   logic o_user_idle_clock, o_internal_update_drive_bit, o_configure_select;
   logic o_readback_select, i_config_dout, i_readback_data;
   logic [63:0] din, dout, pre;
   logic        oe_all, t, e;
   int          failures, samples_checked, drck_falls, idle_falls;
   logic [2:0]  codes [4];

   bst_top u_dut (.i_mclk, .i_sys_rst, .i_tck, .i_tms, .i_tdi, .o_tdo, .o_tdo_oe,
      .i_config_done, .i_scan_macro_used, .i_user_tdo_out, .i_user_tdo_oe, .o_fab_tck,
      .o_fab_tms, .o_fab_tdi, .i_pad_in, .i_core_out, .i_core_oe, .o_pad_out, .o_pad_oe,
      .i_mode_pin_low, .i_mode_pin_high, .i_mode_pin_mid, .i_mode_mid_core_out,
      .i_mode_mid_core_oe, .o_mode_pin_mid_out, .o_mode_pin_mid_oe, .o_user_instr_one_select,
      .o_user_instr_two_select, .i_user_chain_one_out, .i_user_chain_two_out,
      .o_user_dr_shift_clock, .o_user_idle_clock, .o_internal_update_drive_bit,
      .o_configure_select, .o_readback_select, .i_config_dout, .i_readback_data);

   bst_jtag_model u_jtag (.i_mclk, .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi),
      .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe));

   initial i_mclk = 1'b0;
   always #2.5 i_mclk = ~i_mclk;
   always @(negedge o_user_dr_shift_clock) drck_falls++;
   always @(negedge o_user_idle_clock) idle_falls++;

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      if (failures == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   function automatic logic [NUM_IOB-1:0] pick(input logic [63:0] v, input int ofs);
      logic [NUM_IOB-1:0] r;
      for (int i = 0; i < NUM_IOB; i++) r[i] = v[POS_IOB + 3 * i + ofs];
      return r;
   endfunction

   // Every load also proves the capture pattern and the driven TDO
   task automatic load_ir(input logic [2:0] c);
      u_jtag.scan(1'b1, IR_LEN, {61'h0, c}, dout, oe_all);
      check(dout[2:0], IR_CAPTURE);
      check(oe_all, 1'b1);
   endtask

   task automatic rand_io();
      @(posedge i_mclk);
      i_pad_in <= NUM_IOB'($urandom);
      i_core_out <= NUM_IOB'($urandom);
      i_core_oe <= NUM_IOB'($urandom);
      {i_mode_pin_low, i_mode_pin_high, i_mode_pin_mid, i_mode_mid_core_out,
       i_mode_mid_core_oe} <= 5'($urandom);
      din = {$urandom, $urandom};
   endtask

   initial begin
      failures = 0;
      samples_checked = 0;
      {i_sys_rst, i_config_done, i_scan_macro_used, i_user_tdo_out, i_user_tdo_oe} = 5'h10;
      {i_pad_in, i_core_out, i_core_oe} = '0;
      {i_mode_pin_low, i_mode_pin_high, i_mode_pin_mid, i_mode_mid_core_out} = 4'h0;
      {i_mode_mid_core_oe, i_user_chain_one_out, i_user_chain_two_out} = 3'h0;
      {i_config_dout, i_readback_data} = 2'h0;
      codes = '{IR_USER1, IR_USER2, IR_READBACK, IR_CONFIGURE};
      void'($urandom(32'hA01C));
      repeat (16) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      repeat (4) @(posedge i_mclk);
      u_jtag.reset_tap();
      idle_falls = 0;
      repeat (4) u_jtag.step(1'b0, 1'b0, t, e);
      check(idle_falls, 4);
      idle_falls = 0;
      repeat (5) u_jtag.step(1'b1, 1'b0, t, e);
      check(idle_falls, 0);
      u_jtag.step(1'b0, 1'b0, t, e);
      load_ir(IR_SAMPLE);
      rand_io();
      u_jtag.scan(1'b0, BSR_LEN + 8, din, dout, oe_all);
      check(pick(dout, OFS_IN), i_pad_in);
      check(pick(dout, OFS_OUT), i_core_out);
      check(pick(dout, OFS_TRI), i_core_oe);
      check(dout[POS_UPD-1:POS_MODE_LO], {i_mode_mid_core_oe, i_mode_mid_core_out,
            i_mode_pin_mid, i_mode_pin_high, i_mode_pin_low});
      check(dout[BSR_LEN+7:BSR_LEN], din[7:0]);
      check(dout[0], 1'b0);
      pre = din >> 8;
      load_ir(IR_EXTEST);
      repeat (2) @(posedge i_mclk);
      check(o_pad_out, pick(pre, OFS_OUT));
      check(o_pad_oe, pick(pre, OFS_TRI));
      check({o_mode_pin_mid_oe, o_mode_pin_mid_out},
            {pre[POS_MODE_MID+OFS_TRI], pre[POS_MODE_MID+OFS_OUT]});
      check(o_internal_update_drive_bit, pre[POS_UPD]);
      repeat (3) begin
         rand_io();
         u_jtag.scan(1'b0, BSR_LEN, din, dout, oe_all);
         check(pick(dout, OFS_IN), i_pad_in);
         repeat (2) @(posedge i_mclk);
         check(o_pad_out, pick(din, OFS_OUT));
         check(o_internal_update_drive_bit, din[POS_UPD]);
      end
      // Reserved code must behave exactly like the all-ones code
      foreach (codes[k]) begin
         load_ir(k[0] ? IR_RESERVED : IR_BYPASS);
         din = {$urandom, $urandom};
         u_jtag.scan(1'b0, 16, din, dout, oe_all);
         check(dout[15:0], {din[14:0], 1'b0});
      end
      foreach (codes[k]) begin
         load_ir(codes[k]);
         @(posedge i_mclk);
         {i_user_chain_one_out, i_user_chain_two_out, i_readback_data,
          i_config_dout} <= 4'h8 >> k;
         check({o_user_instr_one_select, o_user_instr_two_select, o_readback_select,
                o_configure_select}, 4'h8 >> k);
      check(o_pad_oe, (codes[k] == IR_CONFIGURE) ? 8'h00 : i_core_oe);
         drck_falls = 0;
         u_jtag.scan(1'b0, 8, 64'h0, dout, oe_all);
         check({dout[7:0], oe_all}, {8'hFF, 1'b1});
         check(drck_falls >= 8, k < 2);
      end
      @(posedge i_mclk);
      {i_config_done, i_user_tdo_out, i_user_tdo_oe} <= 3'h7;
      repeat (8) @(posedge i_mclk);
      check({o_tdo, o_tdo_oe}, 2'h3);
      u_jtag.scan(1'b1, IR_LEN, 64'h0, dout, oe_all);
      check(dout[2:0], 3'h7);
      i_scan_macro_used <= 1'b1;
      u_jtag.reset_tap();
      load_ir(IR_BYPASS);
      repeat (6) @(posedge i_mclk);
      check({o_fab_tck, o_fab_tms, o_fab_tdi}, {i_tck, i_tms, i_tdi});
      wrap_up();
   end

   // Whole run is near 53 us; over four times that means a hang
   initial begin
      #250000;
      failures++;
      wrap_up();
   end
endmodule
